// ---- asr_regs.svh ----
/*
  Register offsets, field positions, reset values and codes of the AUX
  snoop and lane control block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// ---------------------------------------------------------------
// register offsets on the configuration port
// ---------------------------------------------------------------
`define ASR_ADDR_SNOOP_STATUS  8'h12
`define ASR_ADDR_LANE_CTRL     8'h13
`define ASR_ADDR_LINEARITY     8'h32

// ---------------------------------------------------------------
// reset values and write masks
// ---------------------------------------------------------------
`define ASR_STATUS_RESET       8'h00
`define ASR_LANE_CTRL_RESET    8'h00
`define ASR_LANE_CTRL_WMASK    8'hBF
`define ASR_LIN_RESET          8'h40
`define ASR_READ_UNMAPPED      8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ASR_BYPASS_BIT         7
`define ASR_LIN_HI             5
`define ASR_LIN_LO             4

// ---------------------------------------------------------------
// observed sink configuration addresses and codes
// ---------------------------------------------------------------
`define ASR_SINK_ADDR_POWER    20'h00600
`define ASR_SINK_ADDR_LANES    20'h00101
`define ASR_PWR_DOWN           2'h2
`define ASR_CNT_ONE            5'h01
`define ASR_CNT_TWO            5'h02
`define ASR_CNT_FOUR           5'h04
`define ASR_I2C_BYTE_BITS      4'h8

`endif

// ---- asr_pkg.sv ----
/*
  Types shared by the AUX snoop and lane control block.
  Assumes nothing of its surroundings.
*/
package asr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_PTR       = 4'h3,
    ST_PTR_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8
  } asr_i2c_state_type;

  typedef enum logic [1:0] {
    FS_OFF_LOWEST = 2'h0,
    FS_OFF_IDLE   = 2'h1,
    FS_MAIN_LINK  = 2'h2,
    FS_RESERVED   = 2'h3
  } asr_func_select_type;

endpackage

// ---- asr_pin_sync.sv ----
/*
  Three-stage input synchroniser with agreement filter, one per bit.
  Assumes asynchronous pin inputs and a clock enable from the top.
*/
module asr_pin_sync #(
  parameter int               W    = 3,
  parameter logic [W-1:0]     INIT = '1
) (
  input  wire logic           clk,       // device clock
  input  wire logic           reset_n,   // sync reset, active low
  input  wire logic           ce,        // clock enable
  input  wire logic [W-1:0]   pin_async, // raw pin levels
  output logic      [W-1:0]   pin_sync   // filtered levels
);

  // ---------------------------------------------------------------
  // per-bit chain
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        s1_reg  <= INIT[i];
        s2_reg  <= INIT[i];
        s3_reg  <= INIT[i];
        out_reg <= INIT[i];
      end else if (ce) begin
        s1_reg <= pin_async[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        // change counts once second and third stages agree
        if (s2_reg == s3_reg) begin
          out_reg <= s3_reg;
        end
      end
    end

    assign pin_sync[i] = out_reg;
  end

endmodule // asr_pin_sync

// ---- asr_lane_decode.sv ----
/*
  Next-state lane enable decode from captured snoop values or overrides.
  Assumes registered inputs from the top; output is registered there.
*/
`include "asr_regs.svh"

module asr_lane_decode
  import asr_pkg::*;
(
  input  wire logic [1:0] function_select, // mode from general control
  input  wire logic       bypass,          // snoop bypass bit
  input  wire logic [3:0] lane_off_bits,   // per-lane disable bits
  input  wire logic [1:0] power_state,     // captured power state
  input  wire logic [4:0] lane_count,      // captured lane count
  output logic      [3:0] lane_en_next     // next lane enables
);

  // ---------------------------------------------------------------
  // lane count to mask
  // ---------------------------------------------------------------
  function automatic logic [3:0] lane_mask(input logic [4:0] cnt);
    case (cnt)
      `ASR_CNT_ONE:  lane_mask = 4'h1;
      `ASR_CNT_TWO:  lane_mask = 4'h3;
      `ASR_CNT_FOUR: lane_mask = 4'hF;
      default:       lane_mask = 4'h0;
    endcase
  endfunction

  logic       main_on;
  logic [3:0] snoop_mask;

  assign main_on = (function_select == FS_MAIN_LINK);

  // power-down state switches every lane off unless bypass is set
  assign snoop_mask = (power_state == `ASR_PWR_DOWN) ? 4'h0 :
                      lane_mask(lane_count);

  // ---------------------------------------------------------------
  // per-lane selection
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_lane
    // override bits count only under bypass
    assign lane_en_next[i] = main_on &
      (bypass ? ~lane_off_bits[i] : snoop_mask[i]);
  end

endmodule // asr_lane_decode

// ---- asr_top.sv ----
/*
  AUX snoop status, lane enable control and output linearity registers,
  reached over an I2C target port.
  Assumes: observed AUX writes arrive as a one-cycle decoded pulse on the
  device clock; function select comes from the general control logic on
  the same clock; SCL, SDA and the snoop enable pin are asynchronous.
*/
// Overview of operation
// - write to 0x00600 captured into bits 6-5
// - snooping: lanes follow captured power state
// - write to 0x00101 captured into bits 4-0
// - snooping: only counted lanes on, others off
// - function select upper bit falling clears captures
// - bypass set: lanes follow per-lane disable bits
// - bit 7 selects snoop or register control
// - bits 3-0 disable lanes 3-0 when one
// - disable bits stored but ignored while snooping
// - bits 5-4 select output linearity range
// - linearity register resets to 0x40
// - status register read-only, top bit zero
// - function select codes: off, idle, enabled
// - snoop only while snoop enable pin low
`include "asr_regs.svh"

module asr_top
  import asr_pkg::*;
#(
  parameter logic [6:0] I2C_DEV_ADDR = 7'h44 // arbitrary value
) (
  input  wire logic        clk,                    // 40 MHz clock
  input  wire logic        reset_n,                // sync reset
  input  wire logic        ce,                     // clock enable
  input  wire logic        scl_in,                 // I2C clock pin
  input  wire logic        sda_in,                 // I2C data pin in
  output logic             sda_out,                // I2C data out
  output logic             sda_oe,                 // I2C data drive
  input  wire logic        snoop_enable_n,         // snoop pin
  input  wire logic [1:0]  function_select,        // general mode
  input  wire logic        aux_wr_valid,           // AUX write seen
  input  wire logic        aux_wr_native,          // native request
  input  wire logic        aux_wr_acked,           // reply was ACK
  input  wire logic [19:0] aux_wr_addr,            // AUX address
  input  wire logic [7:0]  aux_wr_data,            // AUX data byte
  output logic      [3:0]  lane_enable,            // main-link lanes
  output logic      [1:0]  output_linearity_level  // linearity code
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  asr_i2c_state_type state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        ptr_reg;
  logic [7:0]        tx_reg;
  logic              rw_reg;
  logic              ack_oe_reg;
  logic              mnack_reg;
  logic              scl_prev_reg;
  logic              sda_prev_reg;
  logic              fs_prev_reg;
  logic [1:0]        pwr_reg;
  logic [4:0]        cnt_reg;
  logic [7:0]        lane_ctrl_reg;
  logic [7:0]        lin_reg;
  logic [3:0]        lane_en_reg;
  logic [3:0]        lane_en_next;
  logic [2:0]        sync_out;
  logic              scl_s;
  logic              sda_s;
  logic              snoop_n_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              i2c_start;
  logic              i2c_stop;
  logic              reg_wr;
  logic              fs_fall;
  logic              cap_ok;
  logic              cap_pwr;
  logic              cap_cnt;
  logic              bypass;
  logic [3:0]        lane_off_bits;
  logic [7:0]        status_byte;
  logic [7:0]        rd_data;
  logic [1:0]        aux_pwr_val;
  logic [4:0]        aux_cnt_val;

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_reg(
    input logic [7:0] a,
    input logic [7:0] st,
    input logic [7:0] lc,
    input logic [7:0] ln
  );
    case (a)
      `ASR_ADDR_SNOOP_STATUS: read_reg = st;
      `ASR_ADDR_LANE_CTRL:    read_reg = lc;
      `ASR_ADDR_LINEARITY:    read_reg = ln;
      default:                read_reg = `ASR_READ_UNMAPPED;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  asr_pin_sync #(
    .W    (3),
    .INIT (3'h7)
  ) u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .pin_async ({snoop_enable_n, sda_in, scl_in}),
    .pin_sync  (sync_out)
  );

  assign scl_s     = sync_out[0];
  assign sda_s     = sync_out[1];
  assign snoop_n_s = sync_out[2];

  // ---------------------------------------------------------------
  // I2C bus conditions
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce) begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  assign i2c_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign i2c_stop  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ---------------------------------------------------------------
  // I2C target state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      tx_reg      <= 8'hFF;
      rw_reg      <= 1'b0;
      ack_oe_reg  <= 1'b0;
      mnack_reg   <= 1'b0;
    end else if (ce) begin
      if (i2c_start) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        ack_oe_reg  <= 1'b0;
      end else if (i2c_stop) begin
        state_reg  <= ST_IDLE;
        ack_oe_reg <= 1'b0;
      end else if (scl_rise) begin
        case (state_reg)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_RDATA: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_RDATA_ACK: begin
            mnack_reg <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == `ASR_I2C_BYTE_BITS) begin
              if (shift_reg[7:1] == I2C_DEV_ADDR) begin
                state_reg  <= ST_ADDR_ACK;
                rw_reg     <= shift_reg[0];
                ack_oe_reg <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            ack_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_RDATA;
              tx_reg    <= rd_data;
              ptr_reg   <= ptr_reg + 8'h01;
            end else begin
              state_reg <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (bit_cnt_reg == `ASR_I2C_BYTE_BITS) begin
              ptr_reg    <= shift_reg;
              state_reg  <= ST_PTR_ACK;
              ack_oe_reg <= 1'b1;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            ack_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= ST_WDATA;
          end
          ST_WDATA: begin
            if (bit_cnt_reg == `ASR_I2C_BYTE_BITS) begin
              ptr_reg    <= ptr_reg + 8'h01;
              state_reg  <= ST_WDATA_ACK;
              ack_oe_reg <= 1'b1;
            end
          end
          ST_RDATA: begin
            if (bit_cnt_reg == `ASR_I2C_BYTE_BITS) begin
              state_reg <= ST_RDATA_ACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b1};
            end
          end
          ST_RDATA_ACK: begin
            if (mnack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg   <= ST_RDATA;
              bit_cnt_reg <= 4'h0;
              tx_reg      <= rd_data;
              ptr_reg     <= ptr_reg + 8'h01;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = ack_oe_reg | ((state_reg == ST_RDATA) & ~tx_reg[7]);
  assign rd_data = read_reg(ptr_reg, status_byte, lane_ctrl_reg, lin_reg);
  assign reg_wr  = ce & scl_fall & ~i2c_start & ~i2c_stop &
                   (state_reg == ST_WDATA) &
                   (bit_cnt_reg == `ASR_I2C_BYTE_BITS);

  // ---------------------------------------------------------------
  // AUX snoop capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fs_prev_reg <= 1'b0;
    end else if (ce) begin
      fs_prev_reg <= function_select[1];
    end
  end

  assign fs_fall = fs_prev_reg & ~function_select[1];
  assign cap_ok  = ~snoop_n_s & ~bypass & aux_wr_valid &
                   aux_wr_native & aux_wr_acked;
  assign cap_pwr = cap_ok & (aux_wr_addr == `ASR_SINK_ADDR_POWER);
  assign cap_cnt = cap_ok & (aux_wr_addr == `ASR_SINK_ADDR_LANES);
  assign aux_pwr_val = aux_wr_data[1:0];
  assign aux_cnt_val = aux_wr_data[4:0];

  // a capture in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_reg <= 2'h0;
      cnt_reg <= 5'h00;
    end else if (ce) begin
      if (cap_pwr) begin
        pwr_reg <= aux_pwr_val;
      end else if (fs_fall) begin
        pwr_reg <= 2'h0;
      end
      if (cap_cnt) begin
        cnt_reg <= aux_cnt_val;
      end else if (fs_fall) begin
        cnt_reg <= 5'h00;
      end
    end
  end

  assign status_byte = {1'b0, pwr_reg, cnt_reg};

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lane_ctrl_reg <= `ASR_LANE_CTRL_RESET;
    end else if (reg_wr && ptr_reg == `ASR_ADDR_LANE_CTRL) begin
      // bit 6 stays zero
      lane_ctrl_reg <= shift_reg & `ASR_LANE_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lin_reg <= `ASR_LIN_RESET;
    end else if (reg_wr && ptr_reg == `ASR_ADDR_LINEARITY) begin
      lin_reg <= shift_reg;
    end
  end

  assign bypass        = lane_ctrl_reg[`ASR_BYPASS_BIT];
  assign lane_off_bits = lane_ctrl_reg[3:0];
  assign output_linearity_level =
    lin_reg[`ASR_LIN_HI:`ASR_LIN_LO];

  // ---------------------------------------------------------------
  // lane enables
  // ---------------------------------------------------------------
  asr_lane_decode u_lane (
    .function_select (function_select),
    .bypass          (bypass),
    .lane_off_bits   (lane_off_bits),
    .power_state     (pwr_reg),
    .lane_count      (cnt_reg),
    .lane_en_next    (lane_en_next)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lane_en_reg <= 4'h0;
    end else if (ce) begin
      lane_en_reg <= lane_en_next;
    end
  end

  assign lane_enable = lane_en_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_pwr_capture;
    ce && cap_pwr |=> pwr_reg == $past(aux_pwr_val);
  endproperty
  a_pwr_capture: assert property (p_pwr_capture)
    else $error("power state not captured");

  property p_cnt_capture;
    ce && cap_cnt |=> cnt_reg == $past(aux_cnt_val);
  endproperty
  a_cnt_capture: assert property (p_cnt_capture)
    else $error("lane count not captured");

  property p_fs_clear;
    ce && fs_fall && !cap_pwr && !cap_cnt |=> status_byte == 8'h00;
  endproperty
  a_fs_clear: assert property (p_fs_clear)
    else $error("status not cleared on select fall");

  property p_snoop_off_hold;
    ce && snoop_n_s && !fs_fall |=> $stable(pwr_reg) && $stable(cnt_reg);
  endproperty
  a_snoop_off_hold: assert property (p_snoop_off_hold)
    else $error("capture while snoop pin inactive");

  property p_bypass_lanes;
    ce && bypass && function_select == FS_MAIN_LINK
      |=> lane_enable == ~$past(lane_off_bits);
  endproperty
  a_bypass_lanes: assert property (p_bypass_lanes)
    else $error("bypass lanes do not follow disable bits");

  property p_snoop_lanes;
    ce && !bypass && function_select == FS_MAIN_LINK &&
      pwr_reg != `ASR_PWR_DOWN && cnt_reg == `ASR_CNT_TWO
      |=> lane_enable == 4'h3;
  endproperty
  a_snoop_lanes: assert property (p_snoop_lanes)
    else $error("two-lane count not decoded");

  property p_pwr_down;
    ce && !bypass && pwr_reg == `ASR_PWR_DOWN |=> lane_enable == 4'h0;
  endproperty
  a_pwr_down: assert property (p_pwr_down)
    else $error("lanes on in power-down state");

  property p_func_off;
    ce && function_select != FS_MAIN_LINK |=> lane_enable == 4'h0;
  endproperty
  a_func_off: assert property (p_func_off)
    else $error("lanes on with main link not selected");

  property p_status_ro;
    reg_wr && ptr_reg == `ASR_ADDR_SNOOP_STATUS && !cap_pwr &&
      !cap_cnt && !fs_fall |=> $stable(status_byte);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status changed by software write");

  property p_lin_write;
    reg_wr && ptr_reg == `ASR_ADDR_LINEARITY
      |=> lin_reg == $past(shift_reg) ##1 $stable(lin_reg) || reg_wr;
  endproperty
  a_lin_write: assert property (p_lin_write)
    else $error("linearity write not stored");

  property p_ce_freeze;
    !ce |=> $stable(lane_enable) && $stable(state_reg) && $stable(pwr_reg);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved with clock enable low");

endmodule // asr_top

// ---- asr_aux_model.sv ----
/*
  AUX observer model: issues decoded write pulses of the snooped channel.
  Assumes the device clock; the pulse is launched at a falling edge.
*/
module asr_aux_model (
  output logic        valid,  // write seen
  output logic        native, // native request
  output logic        acked,  // reply was ack
  output logic [19:0] addr,   // sink address
  output logic [7:0]  data,   // first data byte
  input  wire logic   clk     // device clock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid = 1'b0;
    native = 1'b0;
    acked = 1'b0;
    addr = 20'h0;
    data = 8'h0;
  end
  // one-cycle pulse, then address and data scrambled
  task automatic send(input logic n, input logic a,
                      input logic [19:0] ad, input logic [7:0] d);
    @(negedge clk);
    valid = 1'b1;
    native = n;
    acked = a;
    addr = ad;
    data = d;
    @(negedge clk);
    valid = 1'b0;
    addr = ~ad;
    data = ~d;
  endtask
endmodule // asr_aux_model

// ---- testbench.sv ----
/*
  Self-checking bench for asr_top with an I2C host and an AUX model.
  Assumes asr_pkg, asr_top and asr_aux_model are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  // ----------------------------------------
  // signals and reference state
  // ----------------------------------------
  localparam logic [6:0] DEV = 7'h44; // arbitrary value
  logic       clk, reset_n, scl, sda_m, snoop_n, sda_out, sda_oe, ce;
  logic       v, nat, ack;
  logic [1:0] fsel, lin;
  logic [19:0] ad;
  logic [7:0] dt, rd, wd;
  logic [3:0] lanes;
  wire        sda = sda_m & ~sda_oe;
  int         miscompares, n_compared, seed, pwr, cnt, off, byp;
  logic [7:0] seed_cnt [5] = '{8'h02, 8'h04, 8'h01, 8'h03, 8'h04};

  asr_top #(.I2C_DEV_ADDR(DEV)) dut (.clk(clk), .reset_n(reset_n),
    .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .snoop_enable_n(snoop_n), .function_select(fsel),
    .aux_wr_valid(v), .aux_wr_native(nat), .aux_wr_acked(ack),
    .aux_wr_addr(ad), .aux_wr_data(dt), .lane_enable(lanes),
    .output_linearity_level(lin));
  asr_aux_model u_aux (.valid(v), .native(nat), .acked(ack), .addr(ad),
    .data(dt), .clk(clk));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    conclude;
  end
  function automatic logic [3:0] lanes_ref();
    if (fsel != 2'h2) return 4'h0;
    if (byp != 0) return ~off[3:0];
    if (pwr == 2) return 4'h0;
    case (cnt)
      1: return 4'h1;
      2: return 4'h3;
      4: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction
  // ----------------------------------------
  // host port and AUX stimulus
  // ----------------------------------------
  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    hc(2);
    sda_m = b;
    hc(6);
    scl = 1'b1;
    hc(4);
    r = sda;
    hc(4);
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(1'b1, a);
  endtask
  task automatic start;
    hc(2);
    sda_m = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(6);
    sda_m = 1'b0;
    hc(6);
    scl = 1'b0;
  endtask
  task automatic stop;
    hc(2);
    sda_m = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(6);
    sda_m = 1'b1;
    hc(8);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    start;
    byte_io({DEV, 1'b0}, r);
    byte_io(p, r);
    byte_io(d, r);
    stop;
  endtask
  task automatic rdr(input logic [7:0] p, output logic [7:0] d);
    start;
    byte_io({DEV, 1'b0}, d);
    byte_io(p, d);
    start;
    byte_io({DEV, 1'b1}, d);
    byte_io(8'hFF, d);
    stop;
  endtask
  task automatic aux(input logic n, input logic a, input logic [19:0] adr,
                     input logic [7:0] d);
    u_aux.send(n, a, adr, d);
    if (ce && n && a && !snoop_n && byp == 0) begin
      if (adr == 20'h00600) pwr = d[1:0];
      if (adr == 20'h00101) cnt = d[4:0];
    end
    hc(3);
    check({4'h0, lanes}, {4'h0, lanes_ref()});
  endtask
  task automatic status;
    rdr(8'h12, rd);
    check(rd, {1'b0, 2'(pwr), 5'(cnt)});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h705C;
    ce = 1'b1;
    {scl, sda_m, snoop_n, reset_n, fsel} = 6'h38;
    {miscompares, n_compared, pwr, cnt, off, byp} = '0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    hc(6);
    status;
    rdr(8'h13, rd);
    check(rd, 8'h00);
    rdr(8'h32, rd);
    check(rd, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wd = 8'($random(seed));
      wd[5:4] = 2'(i);
      wr(8'h32, wd);
      hc(3);
      check({6'h0, lin}, 8'(i));
    end
    rdr(8'h32, rd);
    check(rd, wd);
    check({7'h0, sda_out}, 8'h00);
    fsel = 2'h2;
    snoop_n = 1'b0;
    hc(6);
    foreach (seed_cnt[k]) aux(1'b1, 1'b1, 20'h00101, seed_cnt[k]);
    aux(1'b0, 1'b1, 20'h00101, 8'h01);
    aux(1'b1, 1'b0, 20'h00101, 8'h01);
    aux(1'b1, 1'b1, 20'h00102, 8'h01);
    aux(1'b1, 1'b1, 20'h00600, 8'h02);
    status;
    wr(8'h12, 8'h7F);
    status;
    aux(1'b1, 1'b1, 20'h00600, 8'h01);
    wr(8'h13, 8'h05);
    off = 5;
    aux(1'b1, 1'b1, 20'h00101, 8'h04);
    wr(8'h13, 8'hC5);
    byp = 1;
    aux(1'b1, 1'b1, 20'h00101, 8'h01);
    rdr(8'h13, rd);
    check(rd, 8'h85);
    wr(8'h13, 8'h00);
    {byp, off} = '0;
    snoop_n = 1'b1;
    hc(6);
    aux(1'b1, 1'b1, 20'h00101, 8'h02);
    fsel = 2'h3;
    hc(3);
    check({4'h0, lanes}, 8'h00);
    snoop_n = 1'b0;
    fsel = 2'h1;
    {pwr, cnt} = '0;
    hc(3);
    check({4'h0, lanes}, 8'h00);
    fsel = 2'h2;
    status;
    // capture with clock enable low must be lost
    ce = 1'b0;
    aux(1'b1, 1'b1, 20'h00101, 8'h04);
    ce = 1'b1;
    hc(3);
    check({4'h0, lanes}, {4'h0, lanes_ref()});
    aux(1'b1, 1'b1, 20'h00101, 8'h02);
    conclude;
  end
endmodule // testbench
